// file: logic/scc_pkg.sv
package scc_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'hf2;
    localparam logic [7:0] IDX_STAT = 8'hf3;
    localparam logic [7:0] IDX_DATA = 8'hf4;
    localparam logic [7:0] IDX_MASK = 8'hf5;

    // values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [2:0] SYNC_RST = 3'h4;   // select pin idles high

    // status bit positions
    localparam int unsigned ST_DONE = 0;
    localparam int unsigned ST_WCOL = 1;
    localparam int unsigned ST_BUSY = 2;

    // shift engine counts
    localparam logic [3:0] LAST_BIT  = 4'h7;
    localparam logic [3:0] LAST_EDGE = 4'hf;

    // half periods of the shift clock in system clocks
    localparam logic [7:0] HALF_DIV4   = 8'h02;
    localparam logic [7:0] HALF_DIV16  = 8'h08;
    localparam logic [7:0] HALF_DIV64  = 8'h20;
    localparam logic [7:0] HALF_DIV256 = 8'h80;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       irq_en;
        logic       enable;
        logic       msb_first;
        logic       master;
        logic       cpol;
        logic       cpha;
        logic [1:0] rate;
    } scc_ctrl_t;

    typedef enum logic [1:0] {
        SCC_IDLE = 2'b01,
        SCC_RUN  = 2'b10
    } scc_mstate_t;

    function automatic logic [7:0] scc_half(input logic [1:0] rate);
        case (rate)
            2'h0:    return HALF_DIV4;
            2'h1:    return HALF_DIV16;
            2'h2:    return HALF_DIV64;
            default: return HALF_DIV256;
        endcase
    endfunction

endpackage

// file: logic/scc_clk_div.sv
`timescale 1ns/10ps
module scc_clk_div #(
    parameter int CNT_W = 8
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [1:0] rate,
    input  wire logic       run,
    output logic            tick
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] half_m1;

    if (CNT_W < 8) begin : g_chk
        $error("scc_clk_div: CNT_W too small for the slowest rate");
    end

    // counter restarts with each transfer so the first edge gets a full half period
    assign half_m1 = CNT_W'(scc_pkg::scc_half(rate) - 8'h01);
    assign tick    = run && (cnt_q == half_m1);

    always_comb begin
        cnt_d = cnt_q + CNT_W'(1);
        if (!run || tick) begin
            cnt_d = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// file: logic/scc_top.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
// Notes on behaviour
// RULE1 - the interrupt output can only be high while the interrupt enable control bit is set.
// RULE2 - the serial engine runs only while the enable control bit is set and is held idle otherwise.
// RULE3 - the bit order control bit picks least significant first at 0 and most significant first at 1.
// RULE4 - the role bit makes the block a slave on an outside clock at 0 and the clock master at 1.
// RULE5 - the polarity bit sets the idle level of the shift clock, low at 0 and high at 1.
// RULE6 - the phase bit samples data on the leading clock edge at 0 and on the trailing edge at 1.
// RULE7 - as master the shift clock is the system clock divided by 4, 16, 64 or 256 per the rate bits.
// RULE8 - while disabled nothing shifts and neither the shift clock nor the data line is driven.
module scc_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              serial_shift_clock_pin_i,
    output logic                   serial_shift_clock_pin_o,
    output logic                   serial_shift_clock_pin_oe,
    output logic                   sdo_o,
    output logic                   sdo_oe,
    input  wire logic              sdi_i,
    input  wire logic              ssel_n_i,
    output logic                   irq
);

    if (ADDR_W < 10) begin : g_chk
        $error("scc_top: ADDR_W must reach the highest register");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return a == ADDR_W'({idx, 2'b00});
    endfunction

    // ---------------- bus slave state
    logic              aw_have_q, aw_have_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic              w_have_q, w_have_d;
    logic [7:0]        w_data_q, w_data_d;
    logic              w_lane_q, w_lane_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic              rvalid_q, rvalid_d;
    logic [31:0]       rdata_q, rdata_d;
    logic [1:0]        rresp_q, rresp_d;
    logic              do_wr;
    logic              wr_ctrl, wr_stat, wr_data, wr_mask;

    // ---------------- core state
    scc_pkg::scc_ctrl_t   ctrl_q, ctrl_d;
    scc_pkg::scc_mstate_t mst_q, mst_d;
    logic [1:0]           mask_q, mask_d;
    logic [1:0]           st_q, st_d;
    logic [7:0]           tx_q, tx_d;
    logic [7:0]           rx_sr_q, rx_sr_d;
    logic [7:0]           rx_q, rx_d;
    logic [3:0]           bits_q, bits_d;
    logic [3:0]           edge_q, edge_d;
    logic [1:0]           m_smp_q, m_smp_d;
    logic                 sck_q, sck_d;
    logic                 sck_p_q;
    logic [2:0]           sync_a_q, sync_b_q;
    logic                 sck_s, sdi_s, ssel_n_s;
    logic                 m_tick, m_run;
    logic                 lead, trail, sample_ev, shift_ev, take_ev;
    logic                 s_act, s_edge, busy, start;
    logic [7:0]           rx_next;
    logic [1:0]           st_set, st_clr;

    // pins cross into the clock domain through two flops each
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a_q <= scc_pkg::SYNC_RST;
            sync_b_q <= scc_pkg::SYNC_RST;
            sck_p_q  <= 1'b0;
        end else begin
            sync_a_q <= {ssel_n_i, sdi_i, serial_shift_clock_pin_i};
            sync_b_q <= sync_a_q;
            sck_p_q  <= sync_b_q[0];
        end
    end

    assign sck_s    = sync_b_q[0];
    assign sdi_s    = sync_b_q[1];
    assign ssel_n_s = sync_b_q[2];

    // write waits until address and data are both held and no response is pending
    assign do_wr         = aw_have_q && w_have_q && !bvalid_q;
    assign wr_ctrl       = do_wr && w_lane_q && hit(aw_addr_q, scc_pkg::IDX_CTRL);
    assign wr_stat       = do_wr && w_lane_q && hit(aw_addr_q, scc_pkg::IDX_STAT);
    assign wr_data       = do_wr && w_lane_q && hit(aw_addr_q, scc_pkg::IDX_DATA);
    assign wr_mask       = do_wr && w_lane_q && hit(aw_addr_q, scc_pkg::IDX_MASK);
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // bus next state: channels taken independently, one write and one read in flight
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (s_axi_awvalid && !aw_have_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_q) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata[7:0];
            w_lane_d = s_axi_wstrb[0];
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_wr) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            if (hit(aw_addr_q, scc_pkg::IDX_CTRL) || hit(aw_addr_q, scc_pkg::IDX_STAT) ||
                hit(aw_addr_q, scc_pkg::IDX_DATA) || hit(aw_addr_q, scc_pkg::IDX_MASK)) begin
                bresp_d = scc_pkg::RESP_OKAY;
            end else begin
                bresp_d = scc_pkg::RESP_SLVERR;
            end
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d  = scc_pkg::RESP_OKAY;
            if (hit(s_axi_araddr, scc_pkg::IDX_CTRL)) begin
                rdata_d = {24'h000000, ctrl_q};
            end else if (hit(s_axi_araddr, scc_pkg::IDX_STAT)) begin
                rdata_d = {29'h00000000, busy, st_q};
            end else if (hit(s_axi_araddr, scc_pkg::IDX_DATA)) begin
                rdata_d = {24'h000000, rx_q};
            end else if (hit(s_axi_araddr, scc_pkg::IDX_MASK)) begin
                rdata_d = {30'h00000000, mask_q};
            end else begin
                rdata_d = 32'h00000000;
                rresp_d = scc_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= scc_pkg::RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= scc_pkg::RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_lane_q  <= w_lane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign m_run = (mst_q == scc_pkg::SCC_RUN);

    scc_clk_div #(
        .CNT_W (8)
    ) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rate    (ctrl_q.rate),
        .run     (m_run),
        .tick    (m_tick)
    );

    // edge events for both roles; the slave only sees its clock while selected
    assign s_act     = ctrl_q.enable && !ctrl_q.master && !ssel_n_s; // RULE4
    assign s_edge    = s_act && (sck_s != sck_p_q);
    assign lead      = ctrl_q.master ? (m_tick && !edge_q[0]) : (s_edge && (sck_p_q == ctrl_q.cpol)); // RULE5
    assign trail     = ctrl_q.master ? (m_tick && edge_q[0]) : (s_edge && (sck_p_q != ctrl_q.cpol));
    assign sample_ev = ctrl_q.cpha ? trail : lead; // RULE6
    // master reads two clocks late so the input flops hold the bit of this edge
    assign take_ev   = ctrl_q.master ? m_smp_q[1] : sample_ev; // RULE6
    // phase 1 presents the first bit before its leading edge, so that edge skips the shift
    assign shift_ev  = ctrl_q.cpha ? (lead && (ctrl_q.master ? edge_q != 4'h0 : bits_q != 4'h0)) : trail;
    assign busy      = m_run || (m_smp_q != 2'h0) || (s_act && bits_q != 4'h0);
    assign start     = wr_data && !busy && ctrl_q.enable;
    assign rx_next   = ctrl_q.msb_first ? {rx_sr_q[6:0], sdi_s} : {sdi_s, rx_sr_q[7:1]}; // RULE3

    // core next state
    always_comb begin
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        tx_d    = tx_q;
        rx_sr_d = rx_sr_q;
        rx_d    = rx_q;
        bits_d  = bits_q;
        edge_d  = edge_q;
        m_smp_d = ctrl_q.enable ? {m_smp_q[0], ctrl_q.master && sample_ev} : 2'h0;
        mst_d   = mst_q;
        sck_d   = ctrl_q.cpol; // RULE5
        st_set  = 2'h0;
        st_clr  = wr_stat ? w_data_q[1:0] : 2'h0;
        if (wr_ctrl) begin
            ctrl_d = scc_pkg::scc_ctrl_t'(w_data_q);
        end
        if (wr_mask) begin
            mask_d = w_data_q[1:0];
        end
        if (wr_data && busy) begin
            st_set[scc_pkg::ST_WCOL] = 1'b1;
        end
        if (!ctrl_q.enable) begin
            mst_d  = scc_pkg::SCC_IDLE; // RULE2
            bits_d = 4'h0; // RULE8
            edge_d = 4'h0;
        end else begin
            if (shift_ev) begin
                tx_d = ctrl_q.msb_first ? {tx_q[6:0], 1'b0} : {1'b0, tx_q[7:1]}; // RULE3
            end
            if (take_ev) begin
                rx_sr_d = rx_next; // RULE6
                bits_d  = bits_q + 4'h1;
                if (bits_q == scc_pkg::LAST_BIT) begin
                    bits_d                   = 4'h0;
                    rx_d                     = rx_next;
                    st_set[scc_pkg::ST_DONE] = 1'b1;
                end
            end
            if (!ctrl_q.master && ssel_n_s) begin
                bits_d = 4'h0;
            end
            if (m_run) begin
                sck_d = sck_q;
                if (m_tick) begin
                    sck_d  = !sck_q; // RULE7
                    edge_d = edge_q + 4'h1;
                    if (edge_q == scc_pkg::LAST_EDGE) begin
                        mst_d = scc_pkg::SCC_IDLE;
                    end
                end
            end
            if (start) begin
                tx_d = w_data_q;
                if (ctrl_q.master) begin
                    mst_d  = scc_pkg::SCC_RUN; // RULE4
                    edge_d = 4'h0;
                    bits_d = 4'h0;
                end
            end
        end
        // a fresh event beats a clear in the same cycle
        st_d = (st_q & ~st_clr) | st_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q  <= scc_pkg::scc_ctrl_t'(scc_pkg::CTRL_RST);
            mask_q  <= scc_pkg::MASK_RST;
            st_q    <= scc_pkg::STAT_RST;
            tx_q    <= 8'h00;
            rx_sr_q <= 8'h00;
            rx_q    <= 8'h00;
            bits_q  <= 4'h0;
            edge_q  <= 4'h0;
            m_smp_q <= 2'h0;
            mst_q   <= scc_pkg::SCC_IDLE;
            sck_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            mask_q  <= mask_d;
            st_q    <= st_d;
            tx_q    <= tx_d;
            rx_sr_q <= rx_sr_d;
            rx_q    <= rx_d;
            bits_q  <= bits_d;
            edge_q  <= edge_d;
            m_smp_q <= m_smp_d;
            mst_q   <= mst_d;
            sck_q   <= sck_d;
        end
    end

    // pin drivers; the late master read leaves little input margin at the fastest rate
    assign serial_shift_clock_pin_o  = sck_q;
    assign serial_shift_clock_pin_oe = ctrl_q.enable && ctrl_q.master; // RULE8
    assign sdo_o                     = ctrl_q.msb_first ? tx_q[7] : tx_q[0]; // RULE3
    assign sdo_oe                    = ctrl_q.enable && (ctrl_q.master || !ssel_n_s); // RULE8
    assign irq                       = ctrl_q.irq_en && |(st_q & mask_q); // RULE1

    // helper for the divider check: cycles since the last shift clock edge
    logic [7:0] gap_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !m_run || m_tick) begin
            gap_q <= 8'h00;
        end else begin
            gap_q <= gap_q + 8'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_start_msb;
        start && ctrl_q.master && ctrl_q.msb_first;
    endsequence
    sequence s_start_lsb;
        start && ctrl_q.master && !ctrl_q.msb_first;
    endsequence

    property p_irq_gate;
        irq |-> ctrl_q.irq_en;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq high with interrupt disabled"); // RULE1

    property p_irq_fire;
        (ctrl_q.irq_en && (st_q & mask_q) != 2'h0) |-> irq;
    endproperty
    a_irq_fire: assert property (p_irq_fire) else $error("unmasked event without irq"); // RULE1

    property p_disabled_idle;
        !ctrl_q.enable |=> (mst_q == scc_pkg::SCC_IDLE) && bits_q == 4'h0;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("engine active while disabled"); // RULE2

    property p_msb_order;
        s_start_msb |=> sdo_o == $past(w_data_q[7]);
    endproperty
    a_msb_order: assert property (p_msb_order) else $error("msb first not presented"); // RULE3

    property p_lsb_order;
        s_start_lsb |=> sdo_o == $past(w_data_q[0]);
    endproperty
    a_lsb_order: assert property (p_lsb_order) else $error("lsb first not presented"); // RULE3

    property p_slave_no_clk;
        !ctrl_q.master |-> !serial_shift_clock_pin_oe && !m_run;
    endproperty
    a_slave_no_clk: assert property (p_slave_no_clk) else $error("slave drives shift clock"); // RULE4

    property p_idle_level;
        (ctrl_q.enable && ctrl_q.master && !m_run && $stable(ctrl_q)) |-> sck_q == ctrl_q.cpol;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("shift clock not at idle level"); // RULE5

    property p_lead_sample;
        (m_tick && !edge_q[0] && !ctrl_q.cpha && ctrl_q.msb_first) |-> ##3 rx_sr_q[0] == $past(sdi_s);
    endproperty
    a_lead_sample: assert property (p_lead_sample) else $error("phase 0 missed leading sample"); // RULE6

    property p_trail_sample;
        (m_tick && edge_q[0] && ctrl_q.cpha && ctrl_q.msb_first) |-> ##3 rx_sr_q[0] == $past(sdi_s);
    endproperty
    a_trail_sample: assert property (p_trail_sample) else $error("phase 1 missed trailing sample"); // RULE6

    property p_rate;
        m_tick |-> gap_q == scc_pkg::scc_half(ctrl_q.rate) - 8'h01;
    endproperty
    a_rate: assert property (p_rate) else $error("shift clock half period wrong"); // RULE7

    property p_off_quiet;
        !ctrl_q.enable |-> !serial_shift_clock_pin_oe && !sdo_oe;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("pins driven while disabled"); // RULE8

endmodule

// file: verification/scc_spi_peer.sv
`timescale 1ns/10ps
// far-side slave: shifts one byte in and out in the configured mode
module scc_spi_peer (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       msb_first,
    input  wire logic       arm,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    int   n_smp  = 0;
    logic active = 1'b0;

    function automatic logic pick(input int k);
        return msb_first ? tx_byte[7-k] : tx_byte[k];
    endfunction

    initial begin
        miso    = 1'b0;
        rx_byte = 8'h00;
    end

    // phase 0 needs the first bit on the line before the first edge
    always @(posedge arm) begin
        active  = 1'b1;
        n_smp   = 0;
        rx_byte = 8'h00;
        miso    = cpha ? ~miso : pick(0);
    end

    // leading edge leaves the idle level; sample edge is leading xor phase
    always @(sck) begin
        if (active && (sck === 1'b0 || sck === 1'b1)) begin
            if ((sck !== cpol) ^ cpha) begin
                rx_byte = msb_first ? {rx_byte[6:0], mosi} : {mosi, rx_byte[7:1]};
                n_smp++;
                if (n_smp == 8 && cpha) begin
                    active = 1'b0;
                    miso   = ~miso;  // no stale bit left after the frame
                end
            end else if (n_smp < 8) begin
                miso = pick(n_smp);
            end else begin
                active = 1'b0;
                miso   = ~miso;
            end
        end
    end
endmodule

// file: verification/testbench.sv
`timescale 1ns/10ps
`define chk(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", name, exp, got); end end
module testbench;
    localparam logic [11:0] A_CTRL = {2'b00, scc_pkg::IDX_CTRL, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, scc_pkg::IDX_STAT, 2'b00};
    localparam logic [11:0] A_DATA = {2'b00, scc_pkg::IDX_DATA, 2'b00};
    localparam logic [11:0] A_MASK = {2'b00, scc_pkg::IDX_MASK, 2'b00};
    localparam logic [11:0] A_NONE = 12'h000;

    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, sck_i, sck_o, sck_oe, sdo_o, sdo_oe;
    logic        miso, ssel_n, irq, sck_w, mosi_w, arm, peer_cpol, peer_cpha, peer_msb;
    logic        sck_prev = 1'b0;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  peer_tx, peer_rx;
    int          n_tog = 0;
    int          gap = 0;
    int          last_gap = 0;
    int          t0;
    int          n_errors = 0;
    int          cmp_count = 0;
    logic [7:0]  cfg [4] = '{8'h50, 8'h79, 8'h56, 8'h7f};
    logic [7:0]  txs [4] = '{8'h35, 8'hc1, 8'h0e, 8'h9a};
    logic [7:0]  ptxs [4] = '{8'hb2, 8'h4d, 8'h71, 8'he8};

    // a released clock line rests at idle; released data floats
    assign sck_w  = sck_oe ? sck_o : peer_cpol;
    assign mosi_w = sdo_oe ? sdo_o : 1'bz;

    scc_top u_dut (
        .aclk (aclk), .aresetn (aresetn), .s_axi_awaddr (awaddr), .s_axi_awvalid (awvalid),
        .s_axi_awready (awready), .s_axi_wdata (wdata), .s_axi_wstrb (4'hf), .s_axi_wvalid (wvalid),
        .s_axi_wready (wready), .s_axi_bresp (bresp), .s_axi_bvalid (bvalid), .s_axi_bready (bready),
        .s_axi_araddr (araddr), .s_axi_arvalid (arvalid), .s_axi_arready (arready),
        .s_axi_rdata (rdata), .s_axi_rresp (rresp), .s_axi_rvalid (rvalid), .s_axi_rready (rready),
        .serial_shift_clock_pin_i (sck_i), .serial_shift_clock_pin_o (sck_o),
        .serial_shift_clock_pin_oe (sck_oe), .sdo_o (sdo_o), .sdo_oe (sdo_oe), .sdi_i (miso),
        .ssel_n_i (ssel_n), .irq (irq)
    );

    scc_spi_peer u_peer (
        .sck (sck_w), .mosi (mosi_w), .cpol (peer_cpol), .cpha (peer_cpha), .msb_first (peer_msb),
        .arm (arm), .tx_byte (peer_tx), .miso (miso), .rx_byte (peer_rx)
    );

    // 200 MHz system clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // counts shift clock toggles; gap is spacing in system clocks
    always @(posedge aclk) begin
        if (sck_o !== sck_prev) begin
            n_tog    <= n_tog + 1;
            last_gap <= gap;
            gap      <= 1;
        end else begin
            gap <= gap + 1;
        end
        sck_prev <= sck_o;
    end

    task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw, w, ta, tw, got;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= v;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw = 1'b1;
        w  = 1'b1;
        got = 1'b0;
        // both channels offered together, each released when taken
        while (aw || w) begin
            #1;
            ta = aw && (awready === 1'b1);
            tw = w && (wready === 1'b1);
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            aw = aw && !ta;
            w  = w && !tw;
        end
        while (!got) begin
            #1;
            got = (bvalid === 1'b1);
            rs  = bresp;
            @(posedge aclk);
        end
        bready <= 1'b0;
        #1;
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic got;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        got = 1'b0;
        while (!got) begin
            #1;
            got = (arready === 1'b1);
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        got = 1'b0;
        while (!got) begin
            #1;
            got = (rvalid === 1'b1);
            v   = rdata;
            rs  = rresp;
            @(posedge aclk);
        end
        rready <= 1'b0;
        #1;
    endtask

    // settle, then note the toggle count as a baseline
    task automatic settle;
        repeat (4) @(posedge aclk);
        #1;
        t0 = n_tog;
    endtask

    // one master byte exchange with the peer in the given mode
    task automatic xfer(input logic [7:0] ctrl, input logic [7:0] tx, input logic [7:0] ptx);
        int half;
        int cyc;
        half = 2 << (2 * ctrl[1:0]);
        peer_cpol = ctrl[3];
        peer_cpha = ctrl[2];
        peer_msb  = ctrl[5];
        peer_tx   = ptx;
        axi_write(A_CTRL, {24'h0, ctrl}, r);
        settle();
        arm = 1'b1;
        axi_write(A_DATA, {24'h0, tx}, r);
        arm = 1'b0;
        axi_write(A_DATA, {24'h0, ~tx}, r);      // second write while busy collides and is dropped
        cyc = 0;
        while (n_tog - t0 < 16 && cyc < 5000) begin
            @(posedge aclk);
            cyc++;
        end
        repeat (2 * half + 4) @(posedge aclk);
        #1;
        `chk("toggles", 16, n_tog - t0)
        `chk("half period", half, last_gap)
        `chk("idle level", ctrl[3], sck_o)
        `chk("master sdo oe", 1'b1, sdo_oe)
        `chk("peer byte", tx, peer_rx)
        axi_read(A_DATA, d, r);
        `chk("dut byte", ptx, d[7:0])
        axi_read(A_STAT, d, r);
        `chk("status", 3'h3, d[2:0])
        $display("test xfer %0h done", ctrl);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // cut a hang short well beyond the expected run
    initial begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        summarize();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, arm, peer_cpol, peer_cpha, peer_msb} = '0;
        {awaddr, araddr, wdata, peer_tx} = '0;
        aresetn = 1'b0;
        sck_i   = 1'b0;
        ssel_n  = 1'b1;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(A_CTRL, d, r);
        `chk("ctrl reset", 32'h0, d)
        axi_read(A_MASK, d, r);
        `chk("mask reset", 32'h0, d)
        `chk("oe reset", 1'b0, sck_oe)
        axi_write(A_NONE, 32'h1, r);
        `chk("bresp unmapped", scc_pkg::RESP_SLVERR, r)
        axi_read(A_NONE, d, r);
        `chk("rresp unmapped", scc_pkg::RESP_SLVERR, r)
        $display("test reset and map done");
        axi_write(A_CTRL, 32'ha5, r);
        axi_read(A_CTRL, d, r);
        `chk("ctrl readback", 32'ha5, d)
        axi_write(A_CTRL, 32'h1c, r);
        settle();
        axi_write(A_DATA, 32'h5a, r);
        repeat (40) @(posedge aclk);
        #1;
        `chk("disabled toggles", 0, n_tog - t0)
        `chk("disabled sck oe", 1'b0, sck_oe)
        `chk("disabled sdo oe", 1'b0, sdo_oe)
        axi_read(A_STAT, d, r);
        `chk("disabled busy", 1'b0, d[2])
        $display("test disabled done");
        axi_write(A_CTRL, 32'h40, r);
        settle();
        `chk("slave sck oe", 1'b0, sck_oe)
        `chk("slave unselected", 1'b0, sdo_oe)
        ssel_n <= 1'b0;
        settle();
        `chk("slave selected", 1'b1, sdo_oe)
        ssel_n <= 1'b1;
        $display("test slave done");
        for (int i = 0; i < 4; i++) begin
            xfer(cfg[i], txs[i], ptxs[i]);
            if (i == 0) begin
                `chk("irq masked", 1'b0, irq)
                axi_write(A_MASK, 32'h1, r);
                `chk("irq disabled", 1'b0, irq)
                axi_write(A_CTRL, 32'hd0, r);
                `chk("irq raised", 1'b1, irq)
            end
            axi_write(A_STAT, 32'h3, r);
            `chk("irq cleared", 1'b0, irq)
        end
        summarize();
    end
endmodule
